// >>> bench/t2rc_assertions.sv
// Port checker for timer 2
`timescale 1ns/10ps
module t2rc_chk (
    input wire logic       i_clk, i_sys_rst, i_sfr_wr, i_t1_ovf,
    input wire logic       i_ext_trigger_pin, o_rx_bit_clk, o_tx_bit_clk,
    input wire logic       o_overflow_irq_flag, o_ext_edge_flag,
    input wire logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic [7:0] c_q;
    wire        cw = i_sfr_wr && i_sfr_addr == 8'hC8;
    always @(posedge i_clk) c_q <= i_sys_rst ? 8'h00 : cw ? i_sfr_wdata : c_q;
    a_unmapped_zero: assert property (
        !(i_sfr_addr inside {8'hC8, [8'hCA:8'hCD]}) |=> o_sfr_rdata == 8'h00)
        else $error("bad read");
    a_ovf_sticky: assert property (
        o_overflow_irq_flag && !cw |=> o_overflow_irq_flag) else $error("ovf");
    a_edge_sticky: assert property (
        o_ext_edge_flag && !cw |=> o_ext_edge_flag) else $error("edge");
    a_baud_no_flag: assert property (
        (c_q[5] | c_q[4]) && !cw && !o_overflow_irq_flag |=>
        !o_overflow_irq_flag) else $error("baud flag");
    a_rx_from_t1: assert property (
        !c_q[5] |=> o_rx_bit_clk == $past(i_t1_ovf)) else $error("rx");
    a_tx_from_t1: assert property (
        !c_q[4] |=> o_tx_bit_clk == $past(i_t1_ovf)) else $error("tx");
    a_edge_needs_en: assert property (
        $rose(o_ext_edge_flag) |-> $past(c_q[3]) ||
        $past(cw && i_sfr_wdata[6])) else $error("edge en");
    a_trig_sets: assert property (
        c_q[3] && !cw && $fell(i_ext_trigger_pin) |-> ##[1:8] o_ext_edge_flag)
        else $error("trig");
    c_reload: cover property ($rose(o_overflow_irq_flag));
    c_capture: cover property ($rose(o_ext_edge_flag));
    c_baud: cover property (o_tx_bit_clk && c_q[4]);
endmodule // t2rc_chk

// >>> bench/t2rc_pins.sv
// Model of trigger pin, count pin and timer 1 overflow source
`timescale 1ns/10ps
module t2rc_pins (
    input  wire logic i_clk,
    output logic      o_trig,
    output logic      o_cnt,
    output logic      o_t1_ovf
);
    int n = 0;
    initial {o_trig, o_cnt, o_t1_ovf} = 3'b110;
    always @(posedge i_clk) begin
        n <= (n + 1) % 5;
        o_t1_ovf <= (n == 0);
    end
    // Pins idle high on pull-ups; a fall outlasts the synchroniser
    task fall(input bit trig);
        @(posedge i_clk);
        if (trig) o_trig <= 0; else o_cnt <= 0;
        repeat (5) @(posedge i_clk);
        {o_trig, o_cnt} <= 2'b11;
        repeat (5) @(posedge i_clk);
    endtask
endmodule // t2rc_pins

// >>> bench/tb.sv
// Self-checking testbench for timer 2
`timescale 1ns/10ps
module tb;
    logic       i_clk = 0, i_sys_rst = 1, i_sfr_wr = 0;
    logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00;
    wire        trig, cnt, t1, rxc, txc, ovf, exf;
    wire  [7:0] o_sfr_rdata;
    int         n_errors = 0, checked = 0;
    always #5 i_clk = ~i_clk;
    t2rc_pins u_t2rc_pins (.i_clk(i_clk), .o_trig(trig), .o_cnt(cnt),
        .o_t1_ovf(t1));
    t2rc_timer u_t2rc_timer (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
        .i_sfr_wr(i_sfr_wr), .o_sfr_rdata(o_sfr_rdata),
        .i_ext_trigger_pin(trig), .i_ext_count_pin(cnt), .i_t1_ovf(t1),
        .o_rx_bit_clk(rxc), .o_tx_bit_clk(txc),
        .o_overflow_irq_flag(ovf), .o_ext_edge_flag(exf));
    task chk(input logic [7:0] s, e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge i_clk);
        {i_sfr_addr, i_sfr_wdata, i_sfr_wr} <= {a, d, 1'b1};
        @(posedge i_clk);
        i_sfr_wr <= 0;
    endtask
    task rd(input logic [7:0] a, e);
        @(posedge i_clk);
        i_sfr_addr <= a;
        repeat (2) @(posedge i_clk);
        #1 chk(o_sfr_rdata, e);
    endtask
    task give_verdict;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #20000 n_errors++;
        give_verdict;
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 0;
        rd(8'hC8, 8'h00);
        rd(8'hC9, 8'h00);
        wr(8'hCA, 8'h34);
        wr(8'hCB, 8'h12);
        wr(8'hCC, 8'hFE);
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'h04);
        repeat (3) @(posedge i_clk);
        #1 chk({7'h00, ovf}, 8'h01);
        rd(8'hCD, 8'h12);
        wr(8'hC8, 8'h00);
        wr(8'hCC, 8'h55);
        rd(8'hCC, 8'h55);
        wr(8'hCD, 8'hFF);
        wr(8'hCC, 8'hFE);
        wr(8'hC8, 8'h34);
        repeat (8) if (txc !== 1'b1) begin
            @(posedge i_clk);
            #1;
        end
        chk({6'h00, rxc, txc}, 8'h03);
        chk({7'h00, ovf}, 8'h00);
        wr(8'hC8, 8'h00);
        wr(8'hCC, 8'h00);
        wr(8'hCD, 8'hAB);
        wr(8'hC8, 8'h0D);
        u_t2rc_pins.fall(1);
        #1 chk({7'h00, exf}, 8'h01);
        rd(8'hCB, 8'hAB);
        wr(8'hC8, 8'h0D);
        #1 chk({7'h00, exf}, 8'h00);
        wr(8'hC8, 8'h00);
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h06);
        repeat (3) u_t2rc_pins.fall(0);
        u_t2rc_pins.fall(1);
        #1 chk({7'h00, exf}, 8'h00);
        rd(8'hCC, 8'h03);
        give_verdict;
    end
endmodule // tb
bind t2rc_timer t2rc_chk u_t2rc_chk (.*);

// >>> hw/t2rc_fall_det.v
// Pin synchroniser with falling edge detector
`timescale 1ns/10ps
module t2rc_fall_det (
    // Clock and reset
    input  wire i_clk,
    input  wire i_sys_rst,
    // Pin
    input  wire i_pin,
    // Falling edge pulse
    output reg  o_fall
);
    reg sync1_q;
    reg sync2_q;
    reg last_q;

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            last_q  <= 1'b1;
            o_fall  <= 1'b0;
        end else begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
            last_q  <= sync2_q;
            o_fall  <= last_q & ~sync2_q;
        end
    end
endmodule // t2rc_fall_det

// >>> hw/t2rc_timer.v
// Timer 2: auto-reload, capture and baud clock source
//
// How it works
// R1 - Three uses: auto-reload counter, capture timer, serial bit clock source
// R2 - Five registers: control, two counter bytes, two reload/capture bytes
// R3 - Overflow sets flag unless a serial clock select is set
// R4 - Enabled falling trigger edge sets edge flag; only software clears it
// R5 - Receive select 1 picks this timer overflow, else timer 1 overflow
// R6 - Transmit select 1 picks this timer overflow, else timer 1 overflow
// R7 - Mode from selects, capture select and run bit; run 0 stops
// R8 - Auto-reload: overflow sets flag and loads counter from reload bytes
// R9 - Capture: overflow sets flag; enabled trigger edge copies counter
// R10 - Counts only while running; source internal clock or count pin falls
`timescale 1ns/10ps
`include "t2rc_consts.vh"
module t2rc_timer (
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_sys_rst,
    // Special-function register bus
    input  wire [7:0] i_sfr_addr,
    input  wire [7:0] i_sfr_wdata,
    input  wire       i_sfr_wr,
    output reg  [7:0] o_sfr_rdata,
    // External pins
    input  wire       i_ext_trigger_pin,
    input  wire       i_ext_count_pin,
    // Timer 1 overflow pulses
    input  wire       i_t1_ovf,
    // Serial port bit clocks and flags
    output reg        o_rx_bit_clk,
    output reg        o_tx_bit_clk,
    output reg        o_overflow_irq_flag,
    output reg        o_ext_edge_flag
);
    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    reg  [7:0]  ctrl_q;
    reg  [15:0] cnt_q;
    reg  [15:0] rld_q;
    reg  [7:0]  ctrl_d;
    reg  [15:0] cnt_d;
    reg  [15:0] rld_d;
    wire        trig_fall;
    wire        cnt_fall;
    reg  [3:0]  mode;
    reg  [7:0]  rd_d;
    wire        wr_rll;
    wire        wr_rlh;
    wire        wr_cntl;
    wire        wr_cnth;

    // One-hot operating modes
    localparam MODE_STOP    = 4'h1;
    localparam MODE_RELOAD  = 4'h2;
    localparam MODE_CAPTURE = 4'h4;
    localparam MODE_BAUD    = 4'h8;

    t2rc_fall_det u_trig (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_pin     (i_ext_trigger_pin),
        .o_fall    (trig_fall)
    );

    t2rc_fall_det u_cnt (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_pin     (i_ext_count_pin),
        .o_fall    (cnt_fall)
    );

    // ---------------------------------------------------------------
    // Mode decode
    // ---------------------------------------------------------------
    wire run       = ctrl_q[`T2RC_BIT_RUN];                  // [R7]
    wire baud_mode = ctrl_q[`T2RC_BIT_RCLK] |
                     ctrl_q[`T2RC_BIT_TX_CLOCK_SELECT];                 // [R1] [R7]
    wire cap_mode  = ctrl_q[`T2RC_BIT_CAPSEL] & ~baud_mode;  // [R7]
    wire tick      = run & (ctrl_q[`T2RC_BIT_CNTSRC] ?
                     cnt_fall : 1'b1);                       // [R10]
    wire ovf       = tick & (cnt_q == `T2RC_CNT_MAX);
    wire trig_ev   = trig_fall & ctrl_q[`T2RC_BIT_EXEN];     // [R4]
    wire wr_ctrl   = i_sfr_wr & (i_sfr_addr == `T2RC_ADDR_CTRL);

    // ---------------------------------------------------------------
    // Byte write strobes
    // ---------------------------------------------------------------
    assign wr_rll  = i_sfr_wr & (i_sfr_addr == `T2RC_ADDR_RLL);
    assign wr_rlh  = i_sfr_wr & (i_sfr_addr == `T2RC_ADDR_RLH);
    assign wr_cntl = i_sfr_wr & (i_sfr_addr == `T2RC_ADDR_CNTL);
    assign wr_cnth = i_sfr_wr & (i_sfr_addr == `T2RC_ADDR_CNTH);

    // ---------------------------------------------------------------
    // One-hot operating mode
    // ---------------------------------------------------------------
    always @* begin
        mode = MODE_STOP;
        case ({run, baud_mode, ctrl_q[`T2RC_BIT_CAPSEL]})
            3'b100: begin
                mode = MODE_RELOAD;                          // [R8]
            end
            3'b101: begin
                mode = MODE_CAPTURE;                         // [R9]
            end
            3'b110, 3'b111: begin
                mode = MODE_BAUD;                            // [R1]
            end
            default: begin
                mode = MODE_STOP;                            // [R7]
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Bit clock select
    // ---------------------------------------------------------------
    // Unselected port side keeps the timer 1 pulses
    wire rx_pick = ctrl_q[`T2RC_BIT_RCLK] ? ovf : i_t1_ovf;  // [R5]
    wire tx_pick = ctrl_q[`T2RC_BIT_TX_CLOCK_SELECT] ? ovf : i_t1_ovf;  // [R6]

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always @* begin
        ctrl_d = ctrl_q;
        cnt_d  = cnt_q;
        rld_d  = rld_q;
        // Software writes [R2]
        if (wr_ctrl) begin
            ctrl_d = i_sfr_wdata;
        end
        if (wr_rll) begin
            rld_d[7:0] = i_sfr_wdata;
        end
        if (wr_rlh) begin
            rld_d[15:8] = i_sfr_wdata;
        end
        // Counting
        if (tick) begin
            if (ovf && baud_mode) begin
                cnt_d = rld_q;                               // [R1]
            end else if (ovf && !cap_mode) begin
                cnt_d = rld_q;                               // [R8]
            end else begin
                cnt_d = cnt_q + 16'h0001;                    // [R10]
            end
        end
        if (wr_cntl) begin
            cnt_d[7:0] = i_sfr_wdata;
        end
        if (wr_cnth) begin
            cnt_d[15:8] = i_sfr_wdata;
        end
        // Hardware events win over software clears
        if (ovf && !baud_mode) begin
            ctrl_d[`T2RC_BIT_OVF] = 1'b1;                    // [R3] [R8] [R9]
        end
        if (trig_ev) begin
            ctrl_d[`T2RC_BIT_EXF] = 1'b1;                    // [R4]
            // Capture only while running in capture mode
            if (mode == MODE_CAPTURE) begin
                rld_d = cnt_q;                               // [R9]
            end
        end
    end

    // ---------------------------------------------------------------
    // State and outputs
    // ---------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            ctrl_q              <= `T2RC_CTRL_RST;
            cnt_q               <= {`T2RC_BYTE_RST, `T2RC_BYTE_RST};
            rld_q               <= {`T2RC_BYTE_RST, `T2RC_BYTE_RST};
            o_rx_bit_clk        <= 1'b0;
            o_tx_bit_clk        <= 1'b0;
            o_overflow_irq_flag <= 1'b0;
            o_ext_edge_flag     <= 1'b0;
        end else begin
            ctrl_q              <= ctrl_d;
            cnt_q               <= cnt_d;
            rld_q               <= rld_d;
            o_rx_bit_clk        <= rx_pick;                  // [R5]
            o_tx_bit_clk        <= tx_pick;                  // [R6]
            o_overflow_irq_flag <= ctrl_d[`T2RC_BIT_OVF];
            o_ext_edge_flag     <= ctrl_d[`T2RC_BIT_EXF];
        end
    end

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    // Unmapped addresses read as zero
    always @* begin
        rd_d = 8'h00;
        case (i_sfr_addr)
            `T2RC_ADDR_CTRL: begin
                rd_d = ctrl_q;                               // [R2]
            end
            `T2RC_ADDR_RLL: begin
                rd_d = rld_q[7:0];                           // [R2]
            end
            `T2RC_ADDR_RLH: begin
                rd_d = rld_q[15:8];                          // [R2]
            end
            `T2RC_ADDR_CNTL: begin
                rd_d = cnt_q[7:0];                           // [R2]
            end
            `T2RC_ADDR_CNTH: begin
                rd_d = cnt_q[15:8];                          // [R2]
            end
            default: begin
                rd_d = 8'h00;
            end
        endcase
    end

    // Registered so the bus sees a flop output
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_sfr_rdata <= 8'h00;
        end else begin
            o_sfr_rdata <= rd_d;
        end
    end
endmodule // t2rc_timer

// >>> include/t2rc_consts.vh
// Timer 2 constants: register addresses, control field positions, resets
`ifndef T2RC_CONSTS_VH
`define T2RC_CONSTS_VH

`define T2RC_ADDR_CTRL     8'hC8
`define T2RC_ADDR_RLL      8'hCA
`define T2RC_ADDR_RLH      8'hCB
`define T2RC_ADDR_CNTL     8'hCC
`define T2RC_ADDR_CNTH     8'hCD

`define T2RC_BIT_OVF       7
`define T2RC_BIT_EXF       6
`define T2RC_BIT_RCLK      5
`define T2RC_BIT_TX_CLOCK_SELECT      4
`define T2RC_BIT_EXEN      3
`define T2RC_BIT_RUN       2
`define T2RC_BIT_CNTSRC    1
`define T2RC_BIT_CAPSEL    0

`define T2RC_CTRL_RST      8'h00
`define T2RC_BYTE_RST      8'h00
`define T2RC_CNT_MAX       16'hFFFF

`endif
